// File: hdl/burst_ddr_sram_port.sv
`timescale 1ns/1ps
// How it works
// - Read starts when load low and read-not-write high at input clock rise.
// - Each access moves four 18-bit words; array holds 2M words.
// - Low two address bits seed a burst counter wrapping modulo four.
// - Read words leave on alternate output clock rises after next input rise.
// - Read request on the rise right after an accepted read is ignored.
// - After last read burst, outputs float after next positive output rise.
// - Write starts when load low and read-not-write low at input clock rise.
// - Write words sampled on alternating input rises, then stored as 72 bits.
// - Write request on the rise right after an accepted write is ignored.
// - Deselected writes finish the pending burst then inputs are ignored.
// - Byte selects sampled per word; deasserted byte keeps stored value.
// - Both output clocks high at power-on selects single-clock mode.
// - Finished write is held and committed when the next write finishes.
// - Device starts deselected; load high is a no-op with floating bus.
// - Output impedance recalibrates every 1024 input clock cycles.
// - Echo clocks follow output clocks, or input clocks in single mode.
// - DLL locks after 1024 stable cycles; 30 ns clock stop resets it.
// - Stopped clocks leave the data pins in their previous state.
// - Control inputs are captured only at positive input clock rises.
// - First byte select guards bits 8:0, second guards bits 17:9.
module burst_ddr_sram_port #(
  parameter int CAL_PERIOD      = sram_pkg::CAL_PERIOD,
  parameter int DLL_LOCK_CYCLES = sram_pkg::DLL_LOCK_CYCLES
) (
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  input  wire logic                          k,
  input  wire logic                          k_n,
  input  wire logic                          c,
  input  wire logic                          c_n,
  input  wire logic                          load_strobe_n,
  input  wire logic                          rw,
  input  wire logic [sram_pkg::ADDR_W-1:0]   addr,
  input  wire logic [1:0]                    byte_write_select_n,
  input  wire logic [sram_pkg::WORD_W-1:0]   dq_in,
  input  wire logic                          dll_disable_n,
  output logic      [sram_pkg::WORD_W-1:0]   dq_out,
  output logic                               dq_oe,
  output logic                               echo_clock,
  output logic                               echo_clock_n,
  output logic                               dll_locked,
  output logic                               impedance_update
);
  localparam int SYNC_W = 7 + sram_pkg::ADDR_W + sram_pkg::WORD_W + 2;
  localparam int RAW = sram_pkg::ROW_AW;
  localparam int RW  = sram_pkg::ROW_W;
  localparam int WW  = sram_pkg::WORD_W;

  if (CAL_PERIOD < 2 || CAL_PERIOD > 65535 || DLL_LOCK_CYCLES < 2 || DLL_LOCK_CYCLES > 65535) begin : bad_param
    $error("count parameters must lie in 2..65535");
  end

  typedef struct packed {
    logic                   hreadyout;
    logic [31:0]            hrdata;
    logic                   bus_wr;
    logic [7:0]             bus_addr;
    logic                   recal_en;
    logic [15:0]            cal_count;
    logic [15:0]            cal_div;
    logic                   imp_upd;
    logic [1:0]             strap_cnt;
    logic                   strap_done;
    logic                   single;
    logic                   k_prev;
    logic                   kn_prev;
    logic                   c_prev;
    logic                   cn_prev;
    logic                   last_rd;
    logic                   last_wr;
    logic [15:0]            lock_cnt;
    logic                   locked;
    logic [7:0]             idle_cnt;
    sram_pkg::wr_st_t       wr_st;
    logic                   wq_v;
    logic [RAW-1:0]         wq_row;
    logic [1:0]             wq_lane;
    logic [RAW-1:0]         col_row;
    logic [1:0]             col_lane;
    logic [RW-1:0]          col_data;
    logic [7:0]             col_mask;
    logic                   pend_v;
    logic [RAW-1:0]         pend_row;
    logic [RW-1:0]          pend_data;
    logic [7:0]             pend_mask;
    logic                   mem_we;
    logic [RAW-1:0]         mem_wrow;
    logic [RW-1:0]          mem_wdata;
    logic [7:0]             mem_wmask;
    logic                   rdq_v;
    logic                   rdq_fetch;
    logic                   rdq_ready;
    logic [RAW-1:0]         rdq_row;
    logic [1:0]             rdq_lane;
    logic [RW-1:0]          rdq_data;
    sram_pkg::rd_st_t       rd_st;
    logic [1:0]             rd_lane;
    logic [RW-1:0]          rd_data;
    logic                   rd_last;
    logic [WW-1:0]          dq_out;
    logic                   dq_oe;
    logic                   echo;
    logic                   echo_n;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic [SYNC_W-1:0]                 pins_s;
  logic                              k_s;
  logic                              kn_s;
  logic                              c_s;
  logic                              cn_s;
  logic                              load_n_s;
  logic                              rw_s;
  logic [sram_pkg::ADDR_W-1:0]       addr_s;
  logic [1:0]                        bsel_n_s;
  logic [WW-1:0]                     dq_s;
  logic                              dll_en_s;
  logic [RW-1:0]                     mem_rdata;

  // ----------------------------------------
  // Pin synchronisers and array
  // ----------------------------------------
  sync2 #(.W(SYNC_W)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({k, k_n, c, c_n, load_strobe_n, rw, addr, byte_write_select_n, dq_in, dll_disable_n}),
    .q       (pins_s)
  );

  assign {k_s, kn_s, c_s, cn_s, load_n_s, rw_s, addr_s, bsel_n_s, dq_s, dll_en_s} = pins_s;

  // four 18-bit words per array row
  sram_array #(.ROW_AW(RAW), .ROW_W(RW), .LANE_W(sram_pkg::LANE_W)) u_array (
    .hclk    (hclk),
    .wr_en   (s_reg.mem_we),
    .wr_row  (s_reg.mem_wrow),
    .wr_data (s_reg.mem_wdata),
    .wr_mask (s_reg.mem_wmask),
    .rd_row  (s_reg.rdq_row),
    .rd_data (mem_rdata)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Word of a row by burst lane
  function automatic logic [WW-1:0] lane_word(input logic [RW-1:0] row, input logic [1:0] lane);
    return row[lane*WW +: WW];
  endfunction : lane_word

  // Overlay masked lanes onto a row
  function automatic logic [RW-1:0] merge(input logic [RW-1:0] old, input logic [RW-1:0] nw,
                                          input logic [7:0] mask);
    logic [RW-1:0] r;
    r = old;
    for (int i = 0; i < sram_pkg::LANES; i++) begin
      if (mask[i]) begin
        r[i*sram_pkg::LANE_W +: sram_pkg::LANE_W] = nw[i*sram_pkg::LANE_W +: sram_pkg::LANE_W];
      end
    end
    return r;
  endfunction : merge

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic k_rise;
    logic kn_rise;
    logic op_rise;
    logic on_rise;
    logic acc_rd;
    logic acc_wr;
    logic cap;
    logic done;
    k_rise  = 1'b0;
    kn_rise = 1'b0;
    op_rise = 1'b0;
    on_rise = 1'b0;
    acc_rd  = 1'b0;
    acc_wr  = 1'b0;
    cap     = 1'b0;
    done    = 1'b0;
    s_next  = s_reg;
    s_next.mem_we  = 1'b0;
    s_next.imp_upd = 1'b0;

    // Edge detection on synchronised clocks
    k_rise  = k_s & ~s_reg.k_prev;
    kn_rise = kn_s & ~s_reg.kn_prev;
    s_next.k_prev  = k_s;
    s_next.kn_prev = kn_s;
    s_next.c_prev  = c_s;
    s_next.cn_prev = cn_s;
    op_rise = s_reg.single ? k_rise : (c_s & ~s_reg.c_prev);
    on_rise = s_reg.single ? kn_rise : (cn_s & ~s_reg.cn_prev);

    if (!s_reg.strap_done) begin
      s_next.strap_cnt = s_reg.strap_cnt + 2'd1;
      if (s_reg.strap_cnt == 2'(sram_pkg::STRAP_DELAY)) begin
        s_next.single     = c_s & cn_s;
        s_next.strap_done = 1'b1;
      end
    end

    s_next.echo   = s_reg.single ? k_s : c_s;
    s_next.echo_n = s_reg.single ? kn_s : cn_s;

    // DLL stop detect and lock count
    if (k_rise || kn_rise) begin
      s_next.idle_cnt = '0;
    end else if (s_reg.idle_cnt < 8'(sram_pkg::DLL_STOP_CYC)) begin
      s_next.idle_cnt = s_reg.idle_cnt + 8'd1;
    end
    if (!dll_en_s || s_reg.idle_cnt >= 8'(sram_pkg::DLL_STOP_CYC)) begin
      s_next.lock_cnt = '0;
      s_next.locked   = 1'b0;
    end else if (k_rise && !s_reg.locked) begin
      if (s_reg.lock_cnt == 16'(DLL_LOCK_CYCLES - 1)) begin
        s_next.locked = 1'b1;
      end else begin
        s_next.lock_cnt = s_reg.lock_cnt + 16'd1;
      end
    end

    if (k_rise) begin
      if (s_reg.cal_div == 16'(CAL_PERIOD - 1)) begin
        s_next.cal_div = '0;
        if (s_reg.recal_en) begin
          s_next.imp_upd   = 1'b1;
          s_next.cal_count = s_reg.cal_count + 16'd1;
        end
      end else begin
        s_next.cal_div = s_reg.cal_div + 16'd1;
      end
    end

    // commands taken only at K rise
    if (k_rise) begin
      acc_rd = ~load_n_s & rw_s & ~s_reg.last_rd;
      acc_wr = ~load_n_s & ~rw_s & ~s_reg.last_wr;
      s_next.last_rd = acc_rd;
      s_next.last_wr = acc_wr;
      // Queued read becomes due after next K rise
      if (s_reg.rdq_v) begin
        s_next.rdq_ready = 1'b1;
      end
    end

    if (acc_rd) begin
      s_next.rdq_v     = 1'b1;
      s_next.rdq_fetch = 1'b1;
      s_next.rdq_ready = 1'b0;
      s_next.rdq_row   = addr_s[sram_pkg::ADDR_W-1:2];
      s_next.rdq_lane  = addr_s[1:0];
    end

    // fetch with forwarding from held write
    if (s_reg.rdq_fetch) begin
      s_next.rdq_fetch = 1'b0;
      s_next.rdq_data  = (s_reg.pend_v && s_reg.pend_row == s_reg.rdq_row)
                        ? merge(mem_rdata, s_reg.pend_data, s_reg.pend_mask) : mem_rdata;
    end

    if (acc_wr) begin
      if (s_reg.wr_st == sram_pkg::WR_IDLE) begin
        s_next.wr_st    = sram_pkg::WR_ARMED;
        s_next.col_row  = addr_s[sram_pkg::ADDR_W-1:2];
        s_next.col_lane = addr_s[1:0];
        s_next.col_mask = '0;
      end else begin
        s_next.wq_v    = 1'b1;
        s_next.wq_row  = addr_s[sram_pkg::ADDR_W-1:2];
        s_next.wq_lane = addr_s[1:0];
      end
    end

    // data on K, K#, K, K# after the load
    case (s_reg.wr_st)
      sram_pkg::WR_ARMED: cap = k_rise;
      sram_pkg::WR_W1:    cap = kn_rise;
      sram_pkg::WR_W2:    cap = k_rise;
      sram_pkg::WR_W3:    cap = kn_rise;
      default:            cap = 1'b0;
    endcase
    if (cap) begin
      s_next.col_data[s_reg.col_lane*WW +: WW] = dq_s;
      s_next.col_mask[{s_reg.col_lane, 1'b0}] = ~bsel_n_s[0];
      s_next.col_mask[{s_reg.col_lane, 1'b1}] = ~bsel_n_s[1];
      s_next.col_lane = s_reg.col_lane + 2'd1;
      case (s_reg.wr_st)
        sram_pkg::WR_ARMED: s_next.wr_st = sram_pkg::WR_W1;
        sram_pkg::WR_W1:    s_next.wr_st = sram_pkg::WR_W2;
        sram_pkg::WR_W2:    s_next.wr_st = sram_pkg::WR_W3;
        default:            done = 1'b1;
      endcase
    end

    // commit older held write, hold the new one
    if (done) begin
      s_next.mem_we    = s_reg.pend_v;
      s_next.mem_wrow  = s_reg.pend_row;
      s_next.mem_wdata = s_reg.pend_data;
      s_next.mem_wmask = s_reg.pend_mask;
      s_next.pend_v    = 1'b1;
      s_next.pend_row  = s_next.col_row;
      s_next.pend_data = s_next.col_data;
      s_next.pend_mask = s_next.col_mask;
      // idle unless another write is queued
      if (s_reg.wq_v || acc_wr) begin
        s_next.wr_st    = sram_pkg::WR_ARMED;
        s_next.col_row  = acc_wr ? addr_s[sram_pkg::ADDR_W-1:2] : s_reg.wq_row;
        s_next.col_lane = acc_wr ? addr_s[1:0] : s_reg.wq_lane;
        s_next.col_mask = '0;
        s_next.wq_v     = 1'b0;
      end else begin
        s_next.wr_st = sram_pkg::WR_IDLE;
      end
    end

    // first word on negative output rise
    if (on_rise) begin
      if (s_reg.rd_st == sram_pkg::RD_IDLE && s_reg.rdq_ready) begin
        s_next.rd_data   = s_reg.rdq_data;
        s_next.dq_out    = lane_word(s_reg.rdq_data, s_reg.rdq_lane);
        s_next.dq_oe     = 1'b1;
        s_next.rd_lane   = s_reg.rdq_lane + 2'd1;
        s_next.rd_st     = sram_pkg::RD_W1;
        s_next.rd_last   = 1'b0;
        s_next.rdq_v     = 1'b0;
        s_next.rdq_ready = 1'b0;
      end else if (s_reg.rd_st == sram_pkg::RD_W2) begin
        s_next.dq_out  = lane_word(s_reg.rd_data, s_reg.rd_lane);
        s_next.rd_lane = s_reg.rd_lane + 2'd1;
        s_next.rd_st   = sram_pkg::RD_W3;
      end
    end

    // second and fourth words on positive output rise
    if (op_rise) begin
      case (s_reg.rd_st)
        sram_pkg::RD_W1: begin
          s_next.dq_out  = lane_word(s_reg.rd_data, s_reg.rd_lane);
          s_next.rd_lane = s_reg.rd_lane + 2'd1;
          s_next.rd_st   = sram_pkg::RD_W2;
        end
        sram_pkg::RD_W3: begin
          s_next.dq_out  = lane_word(s_reg.rd_data, s_reg.rd_lane);
          s_next.rd_st   = sram_pkg::RD_IDLE;
          s_next.rd_last = 1'b1;
        end
        default: begin
          // float after the following C rise
          if (s_reg.rd_last && !(on_rise && s_reg.rdq_ready)) begin
            s_next.dq_oe   = 1'b0;
            s_next.rd_last = 1'b0;
          end
        end
      endcase
    end

    // Bus data phase write
    s_next.bus_wr = 1'b0;
    if (s_reg.bus_wr && s_reg.bus_addr == sram_pkg::REG_CTRL) begin
      s_next.recal_en = hwdata[sram_pkg::CTRL_RECAL_BIT];
    end

    // Bus address phase
    if (hsel && htrans[1] && hready) begin
      s_next.bus_wr   = hwrite;
      s_next.bus_addr = haddr[7:0];
      s_next.hrdata   = '0;
      if (!hwrite) begin
        case (haddr[7:0])
          sram_pkg::REG_CTRL: s_next.hrdata[sram_pkg::CTRL_RECAL_BIT] = s_reg.recal_en;
          sram_pkg::REG_STATUS: begin
            s_next.hrdata[sram_pkg::STAT_SINGLE_BIT]  = s_reg.single;
            s_next.hrdata[sram_pkg::STAT_LOCKED_BIT]  = s_reg.locked;
            s_next.hrdata[sram_pkg::STAT_RD_BUSY_BIT] = s_reg.rd_st != sram_pkg::RD_IDLE;
            s_next.hrdata[sram_pkg::STAT_WR_PEND_BIT] = s_reg.pend_v;
            s_next.hrdata[sram_pkg::STAT_DLL_EN_BIT]  = dll_en_s;
          end
          sram_pkg::REG_CALCNT: s_next.hrdata[15:0] = s_reg.cal_count;
          default:              s_next.hrdata = '0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // deselected, outputs floating after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg           <= '0;
      s_reg.hreadyout <= 1'b1;
      s_reg.recal_en  <= sram_pkg::CTRL_RECAL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // registered pins hold while clocks stop
  assign hrdata           = s_reg.hrdata;
  assign hreadyout        = s_reg.hreadyout;
  assign hresp            = 1'b0;
  assign dq_out           = s_reg.dq_out;
  assign dq_oe            = s_reg.dq_oe;
  assign echo_clock       = s_reg.echo;
  assign echo_clock_n     = s_reg.echo_n;
  assign dll_locked       = s_reg.locked;
  assign impedance_update = s_reg.imp_upd;
endmodule : burst_ddr_sram_port

// File: hdl/sram_pkg.sv
package sram_pkg;

  // ----------------------------------------
  // Array shape
  // ----------------------------------------
  localparam int ADDR_W  = 21;
  localparam int ROW_AW  = 19;
  localparam int WORD_W  = 18;
  localparam int BURST   = 4;
  localparam int ROW_W   = 72;
  localparam int LANE_W  = 9;
  localparam int LANES   = 8;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CALCNT = 8'h08;
  localparam int CTRL_RECAL_BIT    = 0;
  localparam logic CTRL_RECAL_RESET = 1'b1;
  localparam int STAT_SINGLE_BIT   = 0;
  localparam int STAT_LOCKED_BIT   = 1;
  localparam int STAT_RD_BUSY_BIT  = 2;
  localparam int STAT_WR_PEND_BIT  = 3;
  localparam int STAT_DLL_EN_BIT   = 4;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS   = 8;
  localparam int DLL_STOP_NS     = 30;
  localparam int DLL_STOP_CYC    = (DLL_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLL_LOCK_CYCLES = 1024;
  localparam int CAL_PERIOD      = 1024;
  localparam int STRAP_DELAY     = 3;

  // ----------------------------------------
  // State encodings
  // ----------------------------------------
  typedef enum logic [1:0] {RD_IDLE, RD_W1, RD_W2, RD_W3} rd_st_t;
  typedef enum logic [2:0] {WR_IDLE, WR_ARMED, WR_W1, WR_W2, WR_W3} wr_st_t;

endpackage : sram_pkg

// File: hdl/sync2.sv
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t s_reg;
  sync_t s_next;

  if (W < 1) begin : bad_width
    $error("sync2 width must be positive");
  end

  // Two-stage chain, first stage feeds only the second
  always_comb begin
    s_next    = s_reg;
    s_next.s1 = d;
    s_next.s2 = s_reg.s1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.s2;
endmodule : sync2

// File: hdl/sram_array.sv
`timescale 1ns/1ps
module sram_array #(
  parameter int ROW_AW = sram_pkg::ROW_AW,
  parameter int ROW_W  = sram_pkg::ROW_W,
  parameter int LANE_W = sram_pkg::LANE_W
) (
  input  wire logic                      hclk,
  input  wire logic                      wr_en,
  input  wire logic [ROW_AW-1:0]         wr_row,
  input  wire logic [ROW_W-1:0]          wr_data,
  input  wire logic [ROW_W/LANE_W-1:0]   wr_mask,
  input  wire logic [ROW_AW-1:0]         rd_row,
  output logic      [ROW_W-1:0]          rd_data
);
  logic [ROW_W-1:0] mem [0:(1<<ROW_AW)-1];

  if (ROW_W % LANE_W != 0) begin : bad_lane
    $error("row width must be a whole number of lanes");
  end

  // Lane-masked row write
  always_ff @(posedge hclk) begin
    if (wr_en) begin
      for (int i = 0; i < ROW_W / LANE_W; i++) begin
        if (wr_mask[i]) begin
          mem[wr_row][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // Combinational row read
  assign rd_data = mem[rd_row];
endmodule : sram_array

// File: test/burst_ddr_sram_port_properties.sv
`timescale 1ns/1ps
module port_checker #(
  parameter int CAL_PERIOD = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic c,
  input wire logic c_n,
  input wire logic load_strobe_n,
  input wire logic rw,
  input wire logic dq_oe,
  input wire logic echo_clock,
  input wire logic echo_clock_n,
  input wire logic dll_locked,
  input wire logic impedance_update
);
  localparam int LINK_RATIO = 10; // Bench hclk cycles per input clock period
  int   rd_cnt;
  int   gap;
  logic seen;

  // Age of the last read load and of the last impedance update
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_cnt <= 99;
      gap    <= 0;
      seen   <= 1'b0;
    end else begin
      rd_cnt <= (!load_strobe_n && rw) ? 0 : rd_cnt + 1;
      gap    <= impedance_update ? 0 : gap + 1;
      seen   <= seen | impedance_update;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  echo_pos_a: assert property ($rose(c) |-> ##[2:4] $rose(echo_clock))
    else $error("echo clock lags output clock");
  echo_neg_a: assert property ($rose(c_n) |-> ##[2:4] $rose(echo_clock_n))
    else $error("inverted echo clock lags");
  oe_start_a: assert property ($rose(dq_oe) |-> rd_cnt inside {[3:24]})
    else $error("data driven without a read load");
  oe_span_a: assert property (dq_oe |-> rd_cnt <= 48)
    else $error("data bus driven too long");
  oe_stop_a: assert property ($fell(dq_oe) |-> $past(c, 3))
    else $error("bus released off an output clock rise");
  dll_open_a: assert property (!dll_locked)
    else $error("lock shown with slow input clock");
  cal_pulse_a: assert property (impedance_update |=> !impedance_update)
    else $error("update pulse too long");
  cal_gap_a: assert property (impedance_update && seen |-> gap == CAL_PERIOD * LINK_RATIO - 1)
    else $error("update period wrong");
endmodule : port_checker

bind burst_ddr_sram_port port_checker #(.CAL_PERIOD(CAL_PERIOD)) u_port_checker (
  .hclk(hclk), .hresetn(hresetn), .c(c), .c_n(c_n), .load_strobe_n(load_strobe_n), .rw(rw),
  .dq_oe(dq_oe), .echo_clock(echo_clock), .echo_clock_n(echo_clock_n), .dll_locked(dll_locked),
  .impedance_update(impedance_update));

// File: test/link_ctrl_model.sv
`timescale 1ns/1ps
module link_ctrl_model (
  output logic             k,
  output logic             load_n,
  output logic             rw,
  output logic [20:0]      addr,
  output logic [1:0]       bsel_n,
  output logic [17:0]      dq,
  input  wire logic [17:0] q,
  input  wire logic        q_oe
);
  // Free-running input clock, 80 ns period
  initial begin
    k = 1'b0;
    load_n = 1'b1;
    rw = 1'b1;
    addr = 21'h0;
    bsel_n = 2'b11;
    dq = 18'h0;
    #3;
    forever #40 k = ~k;
  end

  // Present a load before the next K rise, hold it past that rise
  task automatic load(input logic r, input logic [20:0] a);
    @(posedge k) #30;
    load_n <= 1'b0;
    rw <= r;
    addr <= a;
    @(posedge k) #30;
  endtask : load

  // Write burst: words on K, K#, K, K# rises after the load
  // data and selects per word
  task automatic wr(input logic [20:0] a, input logic [71:0] d, input logic [7:0] m);
    load(1'b0, a);
    load_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      dq <= d[i*18 +: 18];
      bsel_n <= m[i*2 +: 2];
      if (i[0]) @(negedge k);
      else @(posedge k);
      #30;
    end
    dq <= ~dq;
    bsel_n <= 2'b11;
  endtask : wr

  // Read burst; load held for a second rise, which must be ignored
  // spacing kept by waiting out the burst
  task automatic rd(input logic [20:0] a, output logic [71:0] d, output logic ok);
    load(1'b1, a);
    @(posedge k) #30;
    load_n <= 1'b1;
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (i[0]) @(posedge k);
      else @(negedge k);
      #36;
      d[i*18 +: 18] = q;
      ok = ok & q_oe;
    end
    @(posedge k) #36;
    ok = ok & !q_oe;
  endtask : rd
endmodule : link_ctrl_model

// File: test/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("mismatch %s expected %0h seen %0h", nm, exp, got); \
  end \
end
module tb_top;
  localparam logic [71:0] DA = 72'h12_3456_789a_bcde_f012;
  localparam logic [71:0] DB = 72'h9c_8a4e_d2b1_5f37_06ad;
  localparam logic [71:0] DC = 72'ha5_5a0f_f0c3_3c96_6912;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        k;
  logic        load_n;
  logic        rw;
  logic [20:0] addr;
  logic [1:0]  bsel_n;
  logic [17:0] dq;
  logic [17:0] q;
  logic        q_oe;
  logic [31:0] r;
  logic [31:0] r0;
  logic [71:0] eb;
  int          bad_count = 0;
  int          num_checks = 0;

  // System clock, 125 MHz
  always #4 hclk = ~hclk;

  burst_ddr_sram_port #(.CAL_PERIOD(8), .DLL_LOCK_CYCLES(8)) u_burst_ddr_sram_port (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(), .k(k), .k_n(~k), .c(k), .c_n(~k), .load_strobe_n(load_n), .rw(rw), .addr(addr),
    .byte_write_select_n(bsel_n), .dq_in(dq), .dll_disable_n(1'b1), .dq_out(q), .dq_oe(q_oe),
    .echo_clock(), .echo_clock_n(), .dll_locked(), .impedance_update());

  link_ctrl_model u_link_ctrl_model (
    .k(k), .load_n(load_n), .rw(rw), .addr(addr), .bsel_n(bsel_n), .dq(dq), .q(q), .q_oe(q_oe));

  // Single AHB transfer: address phase, then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  // Burst lanes seen from another start offset
  function automatic logic [71:0] rot(input logic [71:0] d, input int sh);
    for (int j = 0; j < 4; j++) rot[j*18 +: 18] = d[((j + sh) % 4)*18 +: 18];
  endfunction : rot

  // Read burst and compare words and bus release
  task automatic rd_chk(input logic [20:0] a, input logic [71:0] exp);
    logic [71:0] got;
    logic        ok;
    u_link_ctrl_model.rd(a, got, ok);
    `CHK("read burst", exp, got)
    `CHK("bus drive window", 1'b1, ok)
  endtask : rd_chk

  task automatic report_and_stop;
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    `CHK("idle bus", 1'b0, q_oe)
    ahb(1'b0, 8'h00, 32'h0, r);
    `CHK("ctrl", 32'h1, r)
    ahb(1'b0, 8'h04, 32'h0, r);
    `CHK("status", 32'h10, r)
    ahb(1'b1, 8'h0c, 32'hffff_ffff, r);
    ahb(1'b0, 8'h0c, 32'h0, r);
    `CHK("unmapped", 32'h0, r)
    ahb(1'b0, 8'h08, 32'h0, r0);
    repeat (77) @(posedge hclk);
    ahb(1'b0, 8'h08, 32'h0, r);
    `CHK("update count", r0 + 32'h1, r)
    u_link_ctrl_model.wr(21'h1f_fff5, DA, 8'h00);
    rd_chk(21'h1f_fff5, DA);
    rd_chk(21'h1f_fff4, rot(DA, 3));
    u_link_ctrl_model.wr(21'h00_0008, {72{1'b1}}, 8'h00);
    u_link_ctrl_model.wr(21'h00_0008, DB, 8'he4);
    u_link_ctrl_model.wr(21'h0a_aaac, DC, 8'h00);
    for (int i = 0; i < 4; i++) begin
      eb[i*18 +: 9] = (i == 1 || i == 3) ? 9'h1ff : DB[i*18 +: 9];
      eb[i*18+9 +: 9] = (i >= 2) ? 9'h1ff : DB[i*18+9 +: 9];
    end
    rd_chk(21'h00_0008, eb);
    rd_chk(21'h1f_fff6, rot(DA, 1));
    rd_chk(21'h0a_aaad, rot(DC, 1));
    report_and_stop();
  end

  // Watchdog against a hang
  initial begin
    #20000;
    bad_count++;
    report_and_stop();
  end
endmodule : tb_top
